// ---- design/scrvr_buf2.sv ----
// Two-entry buffer on the outgoing cell stream.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module scrvr_buf2 (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Filling side
   scrvr_stream_if.snk     up,
   // Draining side
   output logic            dn_valid,
   output logic            dn_soc,
   output logic [7:0]      dn_data,
   input  wire logic       dn_ready
);
   import scrvr_pkg::*;

   logic [8:0] mem_reg  [0:1];
   logic [8:0] mem_next [0:1];
   logic       wr_ptr_reg, wr_ptr_next;
   logic       rd_ptr_reg, rd_ptr_next;
   logic [1:0] cnt_reg, cnt_next;
   logic       push, pop;

   // Full refuses the writer, so a stalled receiver loses no byte
   assign up.ready = (cnt_reg != 2'h2);
   assign dn_valid = (cnt_reg != 2'h0);
   assign dn_soc   = mem_reg[rd_ptr_reg][8];
   assign dn_data  = mem_reg[rd_ptr_reg][7:0];
   assign push     = up.valid & up.ready;
   assign pop      = dn_valid & dn_ready;

   // Per-entry storage
   genvar e;
   generate
      for (e = 0; e < 2; e++) begin : g_entry
         always_comb begin
            mem_next[e] = mem_reg[e];
            if (push && (wr_ptr_reg == 1'(e))) begin
               mem_next[e] = {up.soc, up.data};
            end
         end
         always_ff @(posedge clk) begin
            if (rst) begin
               mem_reg[e] <= 9'h000;
            end else begin
               mem_reg[e] <= mem_next[e];
            end
         end
      end
   endgenerate

   // Pointers and fill count
   always_comb begin
      wr_ptr_next = push ? ~wr_ptr_reg : wr_ptr_reg;
      rd_ptr_next = pop ? ~rd_ptr_reg : rd_ptr_reg;
      cnt_next    = cnt_reg;
      if (push && !pop) begin
         cnt_next = cnt_reg + 2'h1;
      end else if (pop && !push) begin
         cnt_next = cnt_reg - 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         cnt_reg    <= 2'h0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         cnt_reg    <= cnt_next;
      end
   end
endmodule
`default_nettype wire

// ---- design/scrvr_core.sv ----
// Command-cell interpreter: revision query, control VCI change and the
// switch reset outputs, on a store-and-forward byte stream of cells.
// Assumes the cell stream is on CLK and the manual reset is an async pin.
`timescale 1ns/1ns
`default_nettype none
module scrvr_core #(
   parameter logic [3:0] REV_MAJOR = 4'h1,  // Arbitrary value
   parameter logic [3:0] REV_MINOR = 4'h0   // Arbitrary value
) (
   // Clock and reset
   input  wire logic       CLK,
   input  wire logic       RST,
   // Incoming cell stream
   input  wire logic       IN_VALID,
   input  wire logic       IN_SOC,
   input  wire logic [7:0] IN_DATA,
   output logic            IN_READY,
   // Outgoing cell stream
   output logic            OUT_VALID,
   output logic            OUT_SOC,
   output logic [7:0]      OUT_DATA,
   input  wire logic       OUT_READY,
   // Manual reset button, active low
   input  wire logic       MANUAL_RESET_N,
   // Reset outputs
   output logic            SWITCH_WIDE_RESET_OUT,
   output logic            CONTROLLER_RESET_OUT,
   output logic [7:0]      PORT_RESET_OUT
);
   import scrvr_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   scrvr_stream_if tx ();

   logic [7:0]   cell_mem [0:CELL_BYTES-1];
   scrvr_state_t state_reg, state_next;
   logic [5:0]   rx_idx_reg, rx_idx_next;
   logic [5:0]   tx_idx_reg, tx_idx_next;
   logic         rev_reg, rev_next;
   logic [7:0]   vci_reg, vci_next;
   logic [4:0]   glob_cnt_reg, glob_cnt_next;
   logic [4:0]   ctrl_cnt_reg, ctrl_cnt_next;
   logic [4:0]   port_cnt_reg, port_cnt_next;
   logic [7:0]   mask_reg, mask_next;
   logic         wide_out_reg, ctrl_out_reg;
   logic [7:0]   port_out_reg;
   logic         man_meta_n_reg, man_sync_n_reg;
   logic         rx_take, rx_store;
   logic [5:0]   rx_addr;
   logic [15:0]  cell_vci;
   logic         is_ctrl_cell;
   logic [7:0]   cmd_byte;
   logic [2:0]   cmd_code;
   logic         do_glob, do_ctrl, do_port;

   // ----------------------------------------------------------------
   // Manual reset synchroniser
   // ----------------------------------------------------------------
   // Two flops on the raw pin, reset to its idle high level so that no
   // false press follows reset; only the second flop is read by logic
   always_ff @(posedge CLK) begin
      if (RST) begin
         man_meta_n_reg <= 1'b1;
         man_sync_n_reg <= 1'b1;
      end else begin
         man_meta_n_reg <= MANUAL_RESET_N;
         man_sync_n_reg <= man_meta_n_reg;
      end
   end

   // ----------------------------------------------------------------
   // Cell receive store
   // ----------------------------------------------------------------
   // Start of cell restarts the index, so a short cell cannot misalign
   // the next one; stray bytes outside a cell are dropped
   assign IN_READY = (state_reg == ST_RECV);
   assign rx_take  = IN_VALID & IN_READY;
   assign rx_store = rx_take & (IN_SOC | (rx_idx_reg != 6'h00));
   assign rx_addr  = IN_SOC ? 6'h00 : rx_idx_reg;

   always_ff @(posedge CLK) begin
      if (rx_store) begin
         cell_mem[rx_addr] <= IN_DATA;
      end
   end

   // ----------------------------------------------------------------
   // Cell decode
   // ----------------------------------------------------------------
   assign cell_vci = {cell_mem[IDX_VCI_HI][3:0], cell_mem[IDX_VCI_MID], cell_mem[IDX_VCI_LO][7:4]};
   assign is_ctrl_cell = (cell_vci == {8'h00, vci_reg});
   assign cmd_byte = cell_mem[IDX_CMD];
   assign cmd_code = cmd_byte[2:0];
   assign do_glob  = (state_reg == ST_EXEC) && is_ctrl_cell && (cmd_code == CMD_GLOBAL);
   assign do_ctrl  = (state_reg == ST_EXEC) && is_ctrl_cell && (cmd_code == CMD_CTRL_RST);
   assign do_port  = (state_reg == ST_EXEC) && is_ctrl_cell && (cmd_code == CMD_PORT_RST);

   // ----------------------------------------------------------------
   // Cell engine
   // ----------------------------------------------------------------
   // One cell at a time: the input stalls while a cell is executed or
   // sent, trading throughput for a single cell store
   always_comb begin
      state_next  = state_reg;
      rx_idx_next = rx_idx_reg;
      tx_idx_next = tx_idx_reg;
      rev_next    = rev_reg;
      vci_next    = vci_reg;
      case (state_reg)
         ST_RECV: begin
            if (rx_store) begin
               rx_idx_next = rx_addr + 6'h01;
               if (rx_addr == CELL_LAST) begin
                  rx_idx_next = 6'h00;
                  state_next  = ST_EXEC;
               end
            end
         end
         ST_EXEC: begin
            tx_idx_next = 6'h00;
            rev_next    = 1'b0;
            if (!is_ctrl_cell) begin
               state_next = ST_SEND;  // Traffic cell passes through
            end else begin
               if (cmd_code == CMD_SET_VCI) begin
                  vci_next = cell_mem[IDX_SUB];
               end
               if (cmd_code == CMD_REVISION) begin
                  rev_next   = 1'b1;
                  state_next = ST_SEND;
               end else if (cmd_byte[CMD_ACK_BIT]) begin
                  state_next = ST_SEND;
               end else begin
                  state_next = ST_RECV;
               end
            end
         end
         ST_SEND: begin
            if (tx.ready) begin
               tx_idx_next = tx_idx_reg + 6'h01;
               if (tx_idx_reg == CELL_LAST) begin
                  state_next = ST_RECV;
               end
            end
         end
         default: begin
            state_next = ST_RECV;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         state_reg  <= ST_RECV;
         rx_idx_reg <= 6'h00;
         tx_idx_reg <= 6'h00;
         rev_reg    <= 1'b0;
         vci_reg    <= VCI_RESET;
      end else begin
         state_reg  <= state_next;
         rx_idx_reg <= rx_idx_next;
         tx_idx_reg <= tx_idx_next;
         rev_reg    <= rev_next;
         vci_reg    <= vci_next;
      end
   end

   // ----------------------------------------------------------------
   // Outgoing cell source
   // ----------------------------------------------------------------
   // reply into stream
   assign tx.valid = (state_reg == ST_SEND);
   assign tx.soc   = (tx_idx_reg == 6'h00);
   // packed version byte; other data bytes echo the request
   assign tx.data  = (rev_reg && (tx_idx_reg == IDX_FIRST_PAYLOAD_BYTE)) ? {REV_MAJOR, REV_MINOR} : cell_mem[tx_idx_reg];

   // Two-entry buffer absorbs a receiver stall
   scrvr_buf2 u_buf (
      .clk      (CLK),
      .rst      (RST),
      .up       (tx.snk),
      .dn_valid (OUT_VALID),
      .dn_soc   (OUT_SOC),
      .dn_data  (OUT_DATA),
      .dn_ready (OUT_READY)
   );

   // ----------------------------------------------------------------
   // Reset pulse generators
   // ----------------------------------------------------------------
   // A new trigger reloads the full width, so back-to-back commands
   // stretch the pulse rather than shortening it
   always_comb begin
      glob_cnt_next = (glob_cnt_reg != RST_CNT_ZERO) ? glob_cnt_reg - 5'h01 : RST_CNT_ZERO;
      ctrl_cnt_next = (ctrl_cnt_reg != RST_CNT_ZERO) ? ctrl_cnt_reg - 5'h01 : RST_CNT_ZERO;
      port_cnt_next = (port_cnt_reg != RST_CNT_ZERO) ? port_cnt_reg - 5'h01 : RST_CNT_ZERO;
      mask_next     = mask_reg;
      if (!man_sync_n_reg || do_glob) begin
         glob_cnt_next = RESET_PULSE_LD;
      end
      if (do_ctrl) begin
         ctrl_cnt_next = RESET_PULSE_LD;
      end
      if (do_port) begin
         port_cnt_next = RESET_PULSE_LD;
         mask_next     = cell_mem[IDX_SUB];
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         glob_cnt_reg <= RESET_PULSE_LD;  // Power-up resets the switch
         ctrl_cnt_reg <= RST_CNT_ZERO;
         port_cnt_reg <= RST_CNT_ZERO;
         mask_reg     <= MASK_RESET;
      end else begin
         glob_cnt_reg <= glob_cnt_next;
         ctrl_cnt_reg <= ctrl_cnt_next;
         port_cnt_reg <= port_cnt_next;
         mask_reg     <= mask_next;
      end
   end

   // ----------------------------------------------------------------
   // Reset output registers
   // ----------------------------------------------------------------
   // sole reset source; output mapping
   always_ff @(posedge CLK) begin
      if (RST) begin
         wide_out_reg <= 1'b1;
         ctrl_out_reg <= 1'b1;
         port_out_reg <= 8'h00;
      end else begin
         wide_out_reg <= (glob_cnt_next != RST_CNT_ZERO);
         ctrl_out_reg <= (glob_cnt_next != RST_CNT_ZERO) || (ctrl_cnt_next != RST_CNT_ZERO);
         port_out_reg <= (port_cnt_next != RST_CNT_ZERO) ? mask_next : 8'h00;
      end
   end

   assign SWITCH_WIDE_RESET_OUT = wide_out_reg;
   assign CONTROLLER_RESET_OUT  = ctrl_out_reg;
   assign PORT_RESET_OUT        = port_out_reg;
endmodule
`default_nettype wire

// ---- design/scrvr_pkg.sv ----
// Package for the command-cell interpreter: cell layout, command codes,
// reset values and reset pulse timing.
// Assumes a 20 MHz system clock and 53-byte cells carried one byte a beat.
`default_nettype none
package scrvr_pkg;

   // ----------------------------------------------------------------
   // Cell layout
   // ----------------------------------------------------------------
   localparam int         CELL_BYTES   = 53;
   localparam logic [5:0] CELL_LAST    = 6'h34;  // Index of byte 52
   localparam logic [5:0] IDX_VCI_HI   = 6'h01;  // VCI[15:12] in bits 3:0
   localparam logic [5:0] IDX_VCI_MID  = 6'h02;  // VCI[11:4]
   localparam logic [5:0] IDX_VCI_LO   = 6'h03;  // VCI[3:0] in bits 7:4
   localparam logic [5:0] IDX_CMD      = 6'h05;  // First payload byte: command
   localparam logic [5:0] IDX_SUB      = 6'h06;  // Sub-command
   localparam logic [5:0] IDX_FIRST_PAYLOAD_BYTE    = 6'h08;  // first_payload_byte of data

   // ----------------------------------------------------------------
   // Command byte fields and codes
   // ----------------------------------------------------------------
   localparam int         CMD_ACK_BIT  = 7;
   localparam logic [2:0] CMD_CTRL_RST = 3'h3;
   localparam logic [2:0] CMD_GLOBAL   = 3'h4;
   localparam logic [2:0] CMD_PORT_RST = 3'h5;
   localparam logic [2:0] CMD_REVISION = 3'h6;
   localparam logic [2:0] CMD_SET_VCI  = 3'h7;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] VCI_RESET    = 8'h10;
   localparam logic [7:0] MASK_RESET   = 8'h00;

   // ----------------------------------------------------------------
   // Reset pulse timing (least time, rounded up)
   // ----------------------------------------------------------------
   localparam int         CLK_PERIOD_NS   = 50;
   localparam int         RESET_PULSE_NS  = 1000;
   localparam int         RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0] RESET_PULSE_LD  = 5'(RESET_PULSE_CYC);
   localparam logic [4:0] RST_CNT_ZERO    = 5'h00;

   // ----------------------------------------------------------------
   // Cell engine states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_RECV = 2'b00,
      ST_EXEC = 2'b01,
      ST_SEND = 2'b10
   } scrvr_state_t;

endpackage
`default_nettype wire

// ---- design/scrvr_stream_if.sv ----
// Byte stream carrier between the cell engine and the output buffer.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface scrvr_stream_if;
   logic       valid;
   logic       ready;
   logic       soc;
   logic [7:0] data;

   modport src (output valid, output soc, output data, input ready);
   modport snk (input valid, input soc, input data, output ready);
endinterface
`default_nettype wire

// ---- tb/scrvr_properties.sv ----
// Checker on the interpreter top ports: cell framing, stalls, reset outputs.
// Assumes one clock CLK and a synchronous active-high RST.
`timescale 1ns/1ns
`default_nettype none
module scrvr_props (
   // Clock and reset
   input wire logic       CLK,
   input wire logic       RST,
   // Incoming cells
   input wire logic       IN_VALID,
   input wire logic       IN_SOC,
   input wire logic [7:0] IN_DATA,
   input wire logic       IN_READY,
   // Outgoing cells
   input wire logic       OUT_VALID,
   input wire logic       OUT_SOC,
   input wire logic [7:0] OUT_DATA,
   input wire logic       OUT_READY,
   // Reset pins
   input wire logic       MANUAL_RESET_N,
   input wire logic       SWITCH_WIDE_RESET_OUT,
   input wire logic       CONTROLLER_RESET_OUT,
   input wire logic [7:0] PORT_RESET_OUT
);
   import scrvr_pkg::*;
   // ------------------------------------------------------------
   // Byte positions and pulse length
   // ------------------------------------------------------------
   logic [5:0] icnt_reg, icnt_next, ocnt_reg, ocnt_next, hi_reg, hi_next;
   // A stray byte without start of cell keeps the count at zero
   always_comb begin
      icnt_next = icnt_reg;
      ocnt_next = ocnt_reg;
      hi_next   = 6'h00;
      if (CONTROLLER_RESET_OUT) hi_next = (hi_reg == 6'h3F) ? hi_reg : hi_reg + 6'h01;
      if (IN_VALID && IN_READY) begin
         icnt_next = IN_SOC ? 6'h01 : ((icnt_reg == 6'h00 || icnt_reg == CELL_LAST) ? 6'h00 : icnt_reg + 6'h01);
      end
      if (OUT_VALID && OUT_READY) ocnt_next = (ocnt_reg == CELL_LAST) ? 6'h00 : ocnt_reg + 6'h01;
   end
   // Counters only register
   always_ff @(posedge CLK) begin
      icnt_reg <= RST ? 6'h00 : icnt_next;
      ocnt_reg <= RST ? 6'h00 : ocnt_next;
      hi_reg   <= RST ? 6'h00 : hi_next;
   end
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   sequence s_last_in;
      IN_VALID && IN_READY && !IN_SOC && icnt_reg == CELL_LAST;
   endsequence
   sequence s_manual;
      !MANUAL_RESET_N [*3];
   endsequence
   property p_exec;      s_last_in |=> !IN_READY; endproperty
   property p_ready_fall; $fell(IN_READY) |-> $past(icnt_reg) == CELL_LAST; endproperty
   property p_ready_back; $fell(IN_READY) |-> ##[1:1000] IN_READY; endproperty
   property p_out_frame; OUT_VALID |-> OUT_SOC == (ocnt_reg == 6'h00); endproperty
   property p_out_hold;
      OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA) && $stable(OUT_SOC);
   endproperty
   property p_manual; s_manual |=> SWITCH_WIDE_RESET_OUT && CONTROLLER_RESET_OUT; endproperty
   property p_wide_ctrl; SWITCH_WIDE_RESET_OUT |-> CONTROLLER_RESET_OUT; endproperty
   property p_ctrl_cause;
      $rose(CONTROLLER_RESET_OUT) |-> !$past(IN_READY) || !$past(MANUAL_RESET_N, 2) || !$past(MANUAL_RESET_N, 3);
   endproperty
   property p_port_cause;
      $changed(PORT_RESET_OUT) && PORT_RESET_OUT != 8'h00 |-> !$past(IN_READY);
   endproperty
   property p_pulse_len; $fell(CONTROLLER_RESET_OUT) |-> hi_reg >= 6'h14; endproperty
   a_exec:       assert property (p_exec) else $error("no execute cycle after last byte");
   a_ready_fall: assert property (p_ready_fall) else $error("input stall outside cell end");
   a_ready_back: assert property (p_ready_back) else $error("input never resumed");
   a_out_frame:  assert property (p_out_frame) else $error("outgoing cell framing wrong");
   a_out_hold:   assert property (p_out_hold) else $error("stalled byte changed");
   a_manual:     assert property (p_manual) else $error("manual press gave no full reset");
   a_wide_ctrl:  assert property (p_wide_ctrl) else $error("wide reset without controller reset");
   a_ctrl_cause: assert property (p_ctrl_cause) else $error("controller reset without cause");
   a_port_cause: assert property (p_port_cause) else $error("port reset without command");
   a_pulse_len:  assert property (p_pulse_len) else $error("reset pulse too short");
endmodule
bind scrvr_core scrvr_props u_props (
   .CLK(CLK), .RST(RST), .IN_VALID(IN_VALID), .IN_SOC(IN_SOC), .IN_DATA(IN_DATA), .IN_READY(IN_READY),
   .OUT_VALID(OUT_VALID), .OUT_SOC(OUT_SOC), .OUT_DATA(OUT_DATA), .OUT_READY(OUT_READY),
   .MANUAL_RESET_N(MANUAL_RESET_N), .SWITCH_WIDE_RESET_OUT(SWITCH_WIDE_RESET_OUT),
   .CONTROLLER_RESET_OUT(CONTROLLER_RESET_OUT), .PORT_RESET_OUT(PORT_RESET_OUT)
);
`default_nettype wire

// ---- tb/scrvr_ws_model.sv ----
// Workstation model: sends whole or cut-short cells, collects every returned byte.
// Assumes it shares the interpreter clock.
`timescale 1ns/1ns
`default_nettype none
module scrvr_ws_model (
   // Clock and pacing
   input  wire logic       clk,
   input  wire logic       slow,
   // Cells toward the interpreter
   output var logic        in_valid,
   output var logic        in_soc,
   output var logic [7:0]  in_data,
   input  wire logic       in_ready,
   // Cells from the interpreter
   input  wire logic       out_valid,
   input  wire logic       out_soc,
   input  wire logic [7:0] out_data,
   output var logic        out_ready
);
   logic [8:0] rxq [$];
   int         seed = 32'hb158;
   // Quiet lines at time zero
   initial begin
      in_valid  = 1'b0;
      in_soc    = 1'b0;
      in_data   = 8'h00;
      out_ready = 1'b1;
   end
   // commands only inside cells
   // Sends the first len bytes; a short len leaves a cut cell behind.
   // Ready only changes on the clock, so it is read between edges
   task send(input logic [7:0] c [53], input int len);
      for (int i = 0; i < len; i++) begin
         in_valid = 1'b1;
         in_soc   = (i == 0);
         in_data  = c[i];
         while (!in_ready) begin
            @(posedge clk);
            #1;
         end
         @(posedge clk);
         #1;
      end
      in_valid = 1'b0;
      in_soc   = 1'b0;
      in_data  = ~c[52];  // Released line shows no stale byte
   endtask
   // Collect bytes; when slow, accept only one cycle in four to fill the buffer
   always @(posedge clk) begin
      if (out_valid && out_ready) rxq.push_back({out_soc, out_data});
      #1 out_ready = !slow || (($random(seed) & 3) == 0);
   end
endmodule
`default_nettype wire

// ---- tb/switch_cmd_revision_vci_reset_tb.sv ----
// Bench for the interpreter: traffic, every command code, reset outputs.
// Assumes the package, design, checker and workstation model are compiled.
`timescale 1ns/1ns
`default_nettype none
module switch_cmd_revision_vci_reset_tb;
   import scrvr_pkg::*;
   typedef logic [7:0] scrvr_cell_t [53];
   localparam logic [7:0] REV = 8'h35;  // Arbitrary, nibbles differ to catch a swap
   logic       clk = 1'b0, rst = 1'b1, man_n = 1'b1, slow = 1'b0;
   logic       iv, isoc, ird, ov, osoc, ordy, sw, ctl;
   logic [7:0] id, od, prt, vci;
   int         seed = 32'hb158, n_mismatch = 0, n_checks = 0, cyc = 0;
   // 50 ns clock
   always #25 clk = ~clk;
   scrvr_core #(.REV_MAJOR(4'h3), .REV_MINOR(4'h5)) dut (
      .CLK(clk), .RST(rst), .IN_VALID(iv), .IN_SOC(isoc), .IN_DATA(id), .IN_READY(ird),
      .OUT_VALID(ov), .OUT_SOC(osoc), .OUT_DATA(od), .OUT_READY(ordy), .MANUAL_RESET_N(man_n),
      .SWITCH_WIDE_RESET_OUT(sw), .CONTROLLER_RESET_OUT(ctl), .PORT_RESET_OUT(prt));
   scrvr_ws_model ws (.clk(clk), .slow(slow), .in_valid(iv), .in_soc(isoc), .in_data(id), .in_ready(ird),
      .out_valid(ov), .out_soc(osoc), .out_data(od), .out_ready(ordy));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task tick;
      @(posedge clk);
      #1;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task report_and_stop;
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Random cell with the given VCI, command and sub-command
   function automatic scrvr_cell_t mk(input logic [15:0] v, input logic [7:0] cmd, input logic [7:0] sub);
      scrvr_cell_t c;
      for (int i = 0; i < 53; i++) c[i] = 8'($random(seed));
      c[1] = {c[1][7:4], v[15:12]};
      c[2] = v[11:4];
      c[3] = {v[3:0], c[3][3:0]};
      c[5] = cmd;
      c[6] = sub;
      return c;
   endfunction
   // Expected reset levels, then length of the pulse in cycles (skip if en<0)
   task chk_rst(input logic w, input logic c, input logic [7:0] p, input int en);
      int n;
      n = 0;
      for (int i = 0; i < 5 && {sw, ctl, prt} === 10'h000; i++) tick;
      chk(sw, w);
      chk(ctl, c);
      chk(prt, p);
      while ({sw, ctl, prt} !== 10'h000 && n < 60) begin
         n++;
         tick;
      end
      if (en >= 0) chk(n, en);
   endtask
   // Compare one returned cell up to byte last; rev puts the version in the first data byte
   task get(input scrvr_cell_t c, input int last, input logic rev);
      logic [8:0] b;
      for (int k = 0; k < 900 && ws.rxq.size() < 53; k++) tick;
      chk(ws.rxq.size() >= 53, 1);
      for (int i = 0; i < 53 && ws.rxq.size() > 0; i++) begin
         b = ws.rxq.pop_front();
         if (i <= last) chk(b, {i == 0, (rev && i == 8) ? REV : c[i]});
      end
   endtask
   // Cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         report_and_stop;
      end
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [7:0]  sub;
      logic [2:0]  code;
      scrvr_cell_t c;
      vci = VCI_RESET;
      repeat (6) @(posedge clk);
      #1 rst = 1'b0;
      chk_rst(1'b1, 1'b1, 8'h00, 20);
      $display("power-up reset done");
      // Upper VCI byte differs only: must pass as traffic, under stalls
      slow = 1'b1;
      c = mk({8'h01, vci}, 8'h06, 8'h00);
      ws.send(c, 53);
      get(c, 52, 1'b0);
      $display("traffic cell done");
      for (int p = 0; p < 2; p++) begin
         for (int k = 0; k < 8; k++) begin
            code = 3'(k);
            sub  = (code == CMD_SET_VCI) ? {p[0], ~p[0], 6'($random(seed))} : 8'($random(seed)) | 8'h01;
            c    = mk({8'h00, vci}, {p[0], 4'($random(seed)), code}, sub);
            ws.send(c, 53);
            chk_rst(code == CMD_GLOBAL, code inside {CMD_GLOBAL, CMD_CTRL_RST}, (code == CMD_PORT_RST) ? sub : 8'h00,
                    (code inside {CMD_GLOBAL, CMD_CTRL_RST, CMD_PORT_RST}) ? 20 : 0);
            if (code == CMD_SET_VCI) vci = sub;
            if (code == CMD_REVISION) get(c, 8, 1'b1);
            else if (p == 1) get(c, 52, 1'b0);
            else begin
               repeat (60) tick;
               chk(ws.rxq.size(), 0);
            end
            $display("command %0d ack %0d done", k, p);
         end
      end
      // The first control VCI is plain traffic now
      // A cut global command is dropped when the next start of cell arrives
      c = mk({8'h00, vci}, {1'b1, 4'h0, CMD_GLOBAL}, 8'hFF);
      ws.send(c, 20);
      c = mk({8'h00, VCI_RESET}, 8'h06, 8'h00);
      ws.send(c, 53);
      chk_rst(1'b0, 1'b0, 8'h00, 0);
      get(c, 52, 1'b0);
      $display("old address done");
      slow  = 1'b0;
      man_n = 1'b0;
      fork
         begin
            repeat (4) tick;
            man_n = 1'b1;
         end
      join_none
      // Four-cycle press: held three more cycles behind the synchroniser, then 20
      chk_rst(1'b1, 1'b1, 8'h00, 23);
      $display("manual reset done");
      report_and_stop;
   end
endmodule
`default_nettype wire
